// ==== preload_observe_pkg.sv ====
package preload_observe_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] CFG_OFS    = 12'h004;
   localparam logic [11:0] STATUS_OFS = 12'h008;
   localparam logic [11:0] STATE_OFS  = 12'h00C;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int MODE_LSB    = 0;
   localparam int POL_LSB     = 0;
   localparam int COMB_LSB    = 8;
   localparam int PORDONE_BIT = 0;
   localparam int STMODE_LSB  = 4;

   // ----------------------------------------
   // reset values and timing
   // ----------------------------------------
   localparam logic [7:0] POL_RST   = 8'h00;
   localparam logic [7:0] COMB_RST  = 8'h00;
   localparam int         CLK_HZ    = 10_000_000;
   localparam int         POR_US    = 10;
   localparam int         POR_CYC   = (POR_US * (CLK_HZ / 1_000_000)) < 1 ? 1 :
                                      (POR_US * (CLK_HZ / 1_000_000));

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_PRELOAD,
      MODE_OBSERVE
   } mode_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

endpackage : preload_observe_pkg

// ==== powerup_reset_preload_observe.sv ====
`timescale 1ns/1ps
module powerup_reset_preload_observe
   import preload_observe_pkg::*;
#(
   parameter int NCELL = 8
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire apb_req_t         apb_req,
   output apb_rsp_t              apb_rsp,
   input  wire logic [NCELL-1:0] cell_d,
   input  wire logic [NCELL-1:0] cell_oe,
   input  wire logic [NCELL-1:0] ar_term,
   input  wire logic [NCELL-1:0] io_in,
   output logic      [NCELL-1:0] io_out,
   output logic      [NCELL-1:0] io_oe
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   mode_t            mode_r;
   logic [NCELL-1:0] pol_r;
   logic [NCELL-1:0] comb_r;
   logic [NCELL-1:0] cell_r;
   logic [NCELL-1:0] cell_nxt;
   logic [NCELL-1:0] out_nxt;
   logic [NCELL-1:0] io_out_r;
   logic [NCELL-1:0] io_oe_r;
   logic [7:0]       por_cnt_r;
   logic             por_done_r;
   logic             pready_r;
   logic             pslverr_r;
   logic [31:0]      prdata_r;
   logic [31:0]      rd_nxt;
   logic             rd_err;
   logic             acc;
   logic             wr_ctrl;
   logic             wr_cfg;

   localparam logic [7:0] POR_LAST = 8'(POR_CYC - 1);

   assign acc     = apb_req.psel && apb_req.penable && pready_r;
   assign wr_ctrl = acc && apb_req.pwrite && (apb_req.paddr == CTRL_OFS);
   assign wr_cfg  = acc && apb_req.pwrite && (apb_req.paddr == CFG_OFS);

   // ----------------------------------------
   // power-up reset timer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_cnt_r  <= 8'h00;
         por_done_r <= 1'b0;
      end else if (!por_done_r) begin
         por_cnt_r <= por_cnt_r + 8'h01;
         if (por_cnt_r == POR_LAST) begin
            por_done_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // mode and configuration registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= MODE_NORMAL;
      end else if (wr_ctrl) begin
         case (apb_req.pwdata[MODE_LSB+:2])
            2'h1:    mode_r <= MODE_PRELOAD;
            2'h2:    mode_r <= MODE_OBSERVE;
            default: mode_r <= MODE_NORMAL;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_r  <= NCELL'(POL_RST);
         comb_r <= NCELL'(COMB_RST);
      end else if (wr_cfg) begin
         pol_r  <= apb_req.pwdata[POL_LSB+:NCELL];
         comb_r <= apb_req.pwdata[COMB_LSB+:NCELL];
      end
   end

   // ----------------------------------------
   // cell flip-flops
   // ----------------------------------------
   always_comb begin
      cell_nxt = cell_r;
      case (mode_r)
         MODE_PRELOAD: cell_nxt = io_in;
         MODE_OBSERVE: cell_nxt = cell_r & ~comb_r;
         MODE_NORMAL:  cell_nxt = cell_d & ~comb_r;
         default:      cell_nxt = cell_r;
      endcase
      if (!por_done_r) begin
         cell_nxt = '0;
      end
      cell_nxt = cell_nxt & ~ar_term;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cell_r <= '0;
      end else begin
         cell_r <= cell_nxt;
      end
   end

   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   always_comb begin
      out_nxt = '0;
      case (mode_r)
         MODE_OBSERVE: out_nxt = (cell_r & ~comb_r) ^ pol_r;
         MODE_PRELOAD: out_nxt = cell_r ^ pol_r;
         MODE_NORMAL:  out_nxt = ((cell_r & ~comb_r) | (cell_d & comb_r)) ^ pol_r;
         default:      out_nxt = '0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_out_r <= '0;
         io_oe_r  <= '0;
      end else begin
         io_out_r <= out_nxt;
         case (mode_r)
            MODE_OBSERVE: io_oe_r <= '1;
            MODE_PRELOAD: io_oe_r <= '0;
            MODE_NORMAL:  io_oe_r <= cell_oe;
            default:      io_oe_r <= '0;
         endcase
      end
   end

   assign io_out = io_out_r;
   assign io_oe  = io_oe_r;

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   always_comb begin
      rd_nxt = 32'h0000_0000;
      rd_err = 1'b0;
      case (apb_req.paddr)
         CTRL_OFS:   rd_nxt[MODE_LSB+:2] = mode_r;
         CFG_OFS: begin
            rd_nxt[POL_LSB+:NCELL]  = pol_r;
            rd_nxt[COMB_LSB+:NCELL] = comb_r;
         end
         STATUS_OFS: begin
            rd_nxt[PORDONE_BIT]   = por_done_r;
            rd_nxt[STMODE_LSB+:2] = mode_r;
         end
         STATE_OFS:  rd_nxt[NCELL-1:0] = cell_r;
         default:    rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r <= apb_req.psel && apb_req.penable && !pready_r;
         if (apb_req.psel && apb_req.penable && !pready_r) begin
            pslverr_r <= rd_err;
            prdata_r  <= apb_req.pwrite ? 32'h0000_0000 : rd_nxt;
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   assign apb_rsp.pready  = pready_r;
   assign apb_rsp.pslverr = pslverr_r;
   assign apb_rsp.prdata  = prdata_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   localparam int POR_MAX = 101;

   sequence por_wait_s;
      (!por_done_r && por_cnt_r == 8'h00);
   endsequence

   sequence enter_obs_s;
      (mode_r == MODE_OBSERVE);
   endsequence

   por_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      por_wait_s |-> ##[1:POR_MAX] por_done_r) else $error("power-up reset too long");
   por_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      !por_done_r |=> cell_r == '0) else $error("cell not cleared in power-up reset");
   por_polar_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!por_done_r && mode_r == MODE_NORMAL && !$past(por_done_r))
      |=> (io_out_r & ~$past(comb_r)) == ($past(pol_r) & ~$past(comb_r)))
      else $error("pin not cleared value through polarity");
   preload_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      (por_done_r && mode_r == MODE_PRELOAD) |=> cell_r == ($past(io_in) & ~$past(ar_term)))
      else $error("preload did not load pins");
   observe_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
      enter_obs_s |=> io_oe_r == '1) else $error("observe did not enable outputs");
   observe_comb_a: assert property (@(posedge pclk) disable iff (!presetn)
      enter_obs_s ##1 enter_obs_s |-> ((io_out_r ^ $past(pol_r)) & $past(comb_r)) == '0)
      else $error("combinatorial data seen in observe");
   comb_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_r == MODE_NORMAL && $stable(pol_r))
      |=> (io_out_r & $past(comb_r)) == (($past(cell_d) ^ $past(pol_r)) & $past(comb_r)))
      else $error("combinatorial output not restored");
   reset_term_a: assert property (@(posedge pclk) disable iff (!presetn)
      ar_term != '0 |=> (cell_r & $past(ar_term)) == '0) else $error("reset term did not clear cell");
   mode_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(mode_r) |-> $past(wr_ctrl)) else $error("mode changed without write");
   normal_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
      mode_r == MODE_NORMAL |=> io_oe_r == $past(cell_oe)) else $error("normal enables not resumed");

endmodule : powerup_reset_preload_observe

// ==== tester_pins.sv ====
`timescale 1ns/1ps
// ---------------------------------
// tester side of the i/o pins
// ---------------------------------
module tester_pins (
   input  wire logic [7:0] drv,
   input  wire logic [7:0] io_out,
   input  wire logic [7:0] io_oe,
   output logic      [7:0] io_in
);
   // pin level: device where enabled, tester elsewhere
   assign io_in = (io_oe & io_out) | (~io_oe & drv);
endmodule : tester_pins

// ==== powerup_reset_preload_observe_tb.sv ====
`timescale 1ns/1ps
module powerup_reset_preload_observe_tb
   import preload_observe_pkg::*;
();
   // ---------------------------------
   // signals
   // ---------------------------------
   logic        pclk = 1'b0;
   logic        presetn;
   apb_req_t    req;
   apb_rsp_t    rsp;
   logic [7:0]  cell_d, cell_oe, ar_term, drv, io_in, io_out, io_oe;
   logic [31:0] q;
   logic        e;
   int          errors = 0;
   int          checks = 0;
   logic [7:0]  ld [3] = '{8'h00, 8'hFF, 8'h5A};
   logic [7:0]  ex [3] = '{8'h0F, 8'hF0, 8'h55};

   always #50 pclk = ~pclk;

   powerup_reset_preload_observe #(.NCELL(8)) u_powerup_reset_preload_observe (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .cell_d(cell_d), .cell_oe(cell_oe), .ar_term(ar_term),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe));

   tester_pins u_tester_pins (.drv(drv), .io_out(io_out), .io_oe(io_oe), .io_in(io_in));

   // ---------------------------------
   // tasks
   // ---------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x) begin
         errors++;
         $display("MISMATCH %s exp %0h got %0h", n, x, g);
      end
   endtask : cmp

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= w;
      req.paddr   <= a;
      req.pwdata  <= d;
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic print_verdict();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // ---------------------------------
   // sequence
   // ---------------------------------
   initial begin
      tick(3000);
      errors++;
      print_verdict();
   end

   initial begin
      req = '0;
      presetn = 1'b0;
      cell_d = 8'hFF;
      cell_oe = 8'h00;
      ar_term = 8'h00;
      drv = 8'h00;
      tick(2);
      presetn <= 1'b1;
      apb(1'b1, CFG_OFS, 32'h0000_00A5);
      apb(1'b0, STATUS_OFS, 32'h0);
      cmp("por_early", 32'h0, q[PORDONE_BIT]);
      apb(1'b0, STATE_OFS, 32'h0);
      cmp("state_por", 32'h0, q[7:0]);
      cmp("pin_pol", 32'hA5, io_out);
      tick(100);
      apb(1'b0, STATUS_OFS, 32'h0);
      cmp("por_done", 32'h1, q[PORDONE_BIT]);
      apb(1'b1, CFG_OFS, 32'h0000_000F);
      for (int i = 0; i < 3; i++) begin
         drv <= ld[i];
         apb(1'b1, CTRL_OFS, 32'h1);
         tick(4);
         cmp("oe_pre", 32'h0, io_oe);
         apb(1'b1, CTRL_OFS, 32'h2);
         tick(3);
         cmp("oe_obs", 32'hFF, io_oe);
         cmp("obs_pin", ex[i], io_out);
         apb(1'b0, STATE_OFS, 32'h0);
         cmp("state", ld[i], q[7:0]);
      end
      apb(1'b0, STATUS_OFS, 32'h0);
      cmp("mode_obs", 32'h2, q[5:4]);
      apb(1'b1, CFG_OFS, 32'h0000_F00F);
      tick(3);
      cmp("comb_obs", 32'h05, io_out);
      cell_d <= 8'h3C;
      cell_oe <= 8'hC3;
      apb(1'b1, CTRL_OFS, 32'h0);
      tick(3);
      cmp("oe_norm", 32'hC3, io_oe);
      cmp("comb_back", 32'h33, io_out);
      apb(1'b1, CFG_OFS, 32'h0000_000F);
      drv <= 8'hFF;
      ar_term <= 8'h81;
      apb(1'b1, CTRL_OFS, 32'h1);
      tick(4);
      apb(1'b0, STATE_OFS, 32'h0);
      cmp("ar_clr", 32'h7E, q[7:0]);
      ar_term <= 8'h00;
      apb(1'b1, CTRL_OFS, 32'h3);
      apb(1'b0, STATUS_OFS, 32'h0);
      cmp("mode3", 32'h0, q[5:4]);
      apb(1'b0, 12'h010, 32'h0);
      cmp("bad_err", 32'h1, e);
      cmp("bad_data", 32'h0, q);
      presetn <= 1'b0;
      tick(2);
      cmp("rst_oe", 32'h0, io_oe);
      presetn <= 1'b1;
      apb(1'b0, STATE_OFS, 32'h0);
      cmp("rst_state", 32'h0, q[7:0]);
      print_verdict();
   end
endmodule : powerup_reset_preload_observe_tb
